//--- rtl/pic_ctrl.sv
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - Fixed ranking: reset, external 0-3, timers 0-2, ADC, watchdog, watch timer, BIT.
// - Each external pin picks falling or rising transition via edge select.
// - Vectoring to an external source clears its request flag.
// - Timer compare match sets that timer's request flag.
// - Interval timer overflow sets its request flag.
// - Conversion finish sets the converter request flag.
// - Watchdog and watch timer flags set by match, sharing one vector.
// - A source whose enable flag is zero is never accepted.
// - Master enable, status word bit 2, blocks all maskable sources.
// - Reset and software break ignore master enable, enables and flags; here break is requested only while no enabled flagged source is pending.
// - Eleven flag sources; flags and enables split into high and low bytes.
// - Latched flag stays until cleared by reset or write; acceptance clears external flags only.
// - Acceptance lasts 8 cycles and clears master enable at its start.
// - Of simultaneous pending requests the higher priority is served.
// - Edge modes per pin: rising only, falling only, or both.
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int unsigned ADDR_W     = 8,
  parameter int unsigned ACCEPT_CYC = ACCEPT_CYCLES
)
(
  input  wire logic              MCLK_I,
  input  wire logic              NRST_I,
  input  wire logic              CE_I,
  input  wire logic [3:0]        EXT_IRQ_PIN_I,
  input  wire pic_evt_t          PERIPH_EVT_I,
  input  wire logic              SOFTWARE_BREAK_I,
  input  wire logic [7:0]        PROCESSOR_STATUS_WORD_I,
  input  wire logic              IRQ_ACK_I,
  output logic                   IRQ_REQ_O,
  output logic [3:0]             IRQ_VECTOR_O,
  output logic                   ACCEPT_BUSY_O,
  output logic                   MASTER_EN_CLEAR_O,
  output logic                   INT_O,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  output logic [1:0]             S_AXI_BRESP_O,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O
);

  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_chk_addr
    $error("ADDR_W must lie between 5 and 8");
  end
  if (ACCEPT_CYC < 1 || ACCEPT_CYC > 255)
  begin : g_chk_acc
    $error("ACCEPT_CYC must lie between 1 and 255");
  end

  // Bus slave state
  logic              aw_q, aw_d, w_q, w_d;
  logic [7:0]        awaddr_q, awaddr_d;
  logic [7:0]        wdata_q, wdata_d;
  logic              wstrb_q, wstrb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              wr_fire, wr_hit;
  logic [7:0]        araddr;

  // Register file and controller state
  logic [15:0]       en_q, en_d, flg_q, flg_d, hw_set, pend;
  logic [7:0]        edge_sel_q, edge_sel_d;
  logic [STAT_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic              int_q, int_d, brk_q, brk_d;
  pic_state_t        st_q, st_d;
  logic [7:0]        cnt_q, cnt_d;
  logic              req_q, req_d, busy_q, busy_d, mclr_q, mclr_d;
  logic [3:0]        vec_q, vec_d, src_q, src_d;
  logic              take, take_brk, acc_done, men, hit;
  logic [3:0]        hit_idx;
  logic [3:0]        ext_edge;

  for (genvar i = 0; i < PIC_NUM_EXT; i++)
  begin : g_ext
    pic_edge_det u_edge (
      .clk_i   (MCLK_I),
      .rst_n_i (NRST_I),
      .ce_i    (CE_I),
      .pin_i   (EXT_IRQ_PIN_I[i]),
      .mode_i  (pic_edge_t'(edge_sel_q[2*i +: 2])),
      .edge_o  (ext_edge[i])
    );
  end

  assign wr_fire = aw_q && w_q && !bvalid_q;
  assign wr_hit  = wr_fire && wstrb_q;
  assign araddr  = 8'(S_AXI_ARADDR_I);

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFF_EN_HIGH)  || (a == OFF_EN_LOW)   ||
           (a == OFF_FLG_HIGH) || (a == OFF_FLG_LOW)  ||
           (a == OFF_EDGE_SEL) || (a == OFF_INT_STAT) ||
           (a == OFF_INT_MASK) || (a == OFF_CTRL_STAT);
  endfunction : is_mapped

  // Bus channels: one write and one read in flight at most
  always_comb
  begin
    aw_d     = aw_q;
    w_d      = w_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (S_AXI_AWVALID_I && awready_q)
    begin
      aw_d     = 1'b1;
      awaddr_d = 8'(S_AXI_AWADDR_I);
    end
    if (S_AXI_WVALID_I && wready_q)
    begin
      w_d     = 1'b1;
      wdata_d = S_AXI_WDATA_I[7:0];
      wstrb_d = S_AXI_WSTRB_I[0];
    end
    if (wr_fire)
    begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && S_AXI_BREADY_I)
    begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && S_AXI_RREADY_I)
    begin
      rvalid_d = 1'b0;
    end
    if (S_AXI_ARVALID_I && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (araddr == OFF_EN_HIGH)
        rdata_d[7:0] = en_q[15:8];
      else if (araddr == OFF_EN_LOW)
        rdata_d[7:0] = en_q[7:0];
      else if (araddr == OFF_FLG_HIGH)
        rdata_d[7:0] = flg_q[15:8];
      else if (araddr == OFF_FLG_LOW)
        rdata_d[7:0] = flg_q[7:0];
      else if (araddr == OFF_EDGE_SEL)
        rdata_d[7:0] = edge_sel_q;
      else if (araddr == OFF_INT_STAT)
        rdata_d[STAT_W-1:0] = stat_q;
      else if (araddr == OFF_INT_MASK)
        rdata_d[STAT_W-1:0] = mask_q;
      else if (araddr == OFF_CTRL_STAT)
        rdata_d[10:0] = {brk_q, busy_q, req_q, src_q, vec_q};
      else
        rresp_d = RESP_SLVERR;
    end
    awready_d = !aw_d && !bvalid_d;
    wready_d  = !w_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      aw_q      <= 1'b0;
      w_q       <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end
    else if (CE_I)
    begin
      aw_q      <= aw_d;
      w_q       <= w_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Hardware set sources; each maps one event onto one flag
  always_comb
  begin
    hw_set            = 16'h0000;
    for (int i = 0; i < PIC_NUM_EXT; i++)
      hw_set[FLG_EXT0-i] = ext_edge[i];
    hw_set[FLG_TMR0]  = PERIPH_EVT_I.tmr_match[0];
    hw_set[FLG_TMR1]  = PERIPH_EVT_I.tmr_match[1];
    hw_set[FLG_TMR2]  = PERIPH_EVT_I.tmr_match[2];
    hw_set[FLG_BIT]   = PERIPH_EVT_I.bit_ovf;
    hw_set[FLG_ADC]   = PERIPH_EVT_I.adc_done;
    hw_set[FLG_WDT]   = PERIPH_EVT_I.wdt_match;
    hw_set[FLG_WT]    = PERIPH_EVT_I.wt_match;
  end

  // Selection of the most urgent enabled source
  assign men  = PROCESSOR_STATUS_WORD_I[PSW_MEN_BIT];
  assign pend = flg_q & en_q & FLG_USED_MASK & {16{men}};

  always_comb
  begin
    hit     = 1'b0;
    hit_idx = 4'h0;
    for (int i = PIC_NUM_PRIO - 1; i >= 0; i--)
    begin
      if (pend[PRIO_ORDER[i]])
      begin
        hit     = 1'b1;
        hit_idx = PRIO_ORDER[i];
      end
    end
  end

  // Acceptance sequence
  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    req_d    = req_q;
    vec_d    = vec_q;
    src_d    = src_q;
    mclr_d   = 1'b0;
    take     = 1'b0;
    acc_done = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (req_q && IRQ_ACK_I)
        begin
          st_d   = ST_ACCEPT;
          cnt_d  = 8'(ACCEPT_CYC - 1);
          req_d  = 1'b0;
          mclr_d = 1'b1;
          take   = 1'b1;
        end
        else if (hit)
        begin
          req_d = 1'b1;
          src_d = hit_idx;
          vec_d = (hit_idx == 4'(FLG_WT)) ? VEC_WDT : hit_idx;
        end
        else
        begin
          req_d = brk_q;
          src_d = VEC_BRK;
          vec_d = VEC_BRK;
        end
      end
      ST_ACCEPT:
      begin
        if (cnt_q == 8'h00)
        begin
          st_d     = ST_IDLE;
          acc_done = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
    busy_d = (st_d == ST_ACCEPT);
  end

  assign take_brk = take && (src_q == VEC_BRK);

  // Register file; every hardware set wins over a same-cycle clear
  always_comb
  begin
    en_d       = en_q;
    flg_d      = flg_q;
    edge_sel_d = edge_sel_q;
    stat_d     = stat_q;
    mask_d     = mask_q;
    brk_d      = brk_q;
    if (wr_hit)
    begin
      if (awaddr_q == OFF_EN_HIGH)
        en_d[15:8] = wdata_q;
      else if (awaddr_q == OFF_EN_LOW)
        en_d[7:0] = wdata_q;
      else if (awaddr_q == OFF_FLG_HIGH)
        flg_d[15:8] = wdata_q;
      else if (awaddr_q == OFF_FLG_LOW)
        flg_d[7:0] = wdata_q;
      else if (awaddr_q == OFF_EDGE_SEL)
        edge_sel_d = wdata_q;
      else if (awaddr_q == OFF_INT_STAT)
        stat_d = stat_q & ~wdata_q[STAT_W-1:0];
      else if (awaddr_q == OFF_INT_MASK)
        mask_d = wdata_q[STAT_W-1:0];
    end
    // Only external flags self-clear; the rest wait for software
    if (take && src_q >= 4'(FLG_EXT3) && src_q <= 4'(FLG_EXT0))
      flg_d[src_q] = 1'b0;
    if (take_brk)
      brk_d = 1'b0;
    brk_d  = brk_d | SOFTWARE_BREAK_I;
    flg_d  = (flg_d | hw_set) & FLG_USED_MASK;
    en_d   = en_d & FLG_USED_MASK;
    stat_d[STAT_ACCEPT] = stat_d[STAT_ACCEPT] | acc_done;
    stat_d[STAT_EXT]    = stat_d[STAT_EXT] | (|ext_edge);
    stat_d[STAT_BRK]    = stat_d[STAT_BRK] | take_brk;
    int_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      en_q       <= RST_EN;
      flg_q      <= RST_FLG;
      edge_sel_q <= RST_EDGE;
      stat_q     <= RST_STAT;
      mask_q     <= RST_MASK;
      int_q      <= 1'b0;
      brk_q      <= 1'b0;
      st_q       <= ST_IDLE;
      cnt_q      <= 8'h00;
      req_q      <= 1'b0;
      vec_q      <= 4'h0;
      src_q      <= 4'h0;
      busy_q     <= 1'b0;
      mclr_q     <= 1'b0;
    end
    else if (CE_I)
    begin
      en_q       <= en_d;
      flg_q      <= flg_d;
      edge_sel_q <= edge_sel_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      int_q      <= int_d;
      brk_q      <= brk_d;
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      req_q      <= req_d;
      vec_q      <= vec_d;
      src_q      <= src_d;
      busy_q     <= busy_d;
      mclr_q     <= mclr_d;
    end
  end

  assign IRQ_REQ_O         = req_q;
  assign IRQ_VECTOR_O      = vec_q;
  assign ACCEPT_BUSY_O     = busy_q;
  assign MASTER_EN_CLEAR_O = mclr_q;
  assign INT_O             = int_q;
  assign S_AXI_AWREADY_O   = awready_q;
  assign S_AXI_WREADY_O    = wready_q;
  assign S_AXI_BVALID_O    = bvalid_q;
  assign S_AXI_BRESP_O     = bresp_q;
  assign S_AXI_ARREADY_O   = arready_q;
  assign S_AXI_RVALID_O    = rvalid_q;
  assign S_AXI_RDATA_O     = rdata_q;
  assign S_AXI_RRESP_O     = rresp_q;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I || !CE_I);

  property p_accept_len;
    $rose(busy_q) |-> busy_q [*8] ##1 !busy_q;
  endproperty
  a_accept_len: assert property (p_accept_len)
    else $error("acceptance did not last eight cycles");

  property p_ext0_first;
    (st_q == ST_IDLE) && !(req_q && IRQ_ACK_I) && pend[FLG_EXT0]
      |=> req_q && vec_q == 4'(FLG_EXT0);
  endproperty
  a_ext0_first: assert property (p_ext0_first)
    else $error("highest pending source not chosen");

  property p_higher_wins;
    (st_q == ST_IDLE) && !(req_q && IRQ_ACK_I) && pend[FLG_TMR0]
      && !(|pend[15:8]) |=> vec_q == 4'(FLG_TMR0);
  endproperty
  a_higher_wins: assert property (p_higher_wins)
    else $error("lower priority source won");

  property p_men_block;
    req_q && vec_q != VEC_BRK |-> $past(men);
  endproperty
  a_men_block: assert property (p_men_block)
    else $error("request raised with master enable clear");

  property p_enable_block;
    // Whole enable word of the previous cycle, indexed by today's source
    req_q && vec_q != VEC_BRK
      |-> (($past(en_q) >> src_q) & 16'h0001) != 16'h0000;
  endproperty
  a_enable_block: assert property (p_enable_block)
    else $error("request raised for a disabled source");

  property p_ext_clear;
    take && src_q == 4'(FLG_EXT0) && !hw_set[FLG_EXT0]
      |=> !flg_q[FLG_EXT0];
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("external flag not cleared on vectoring");

  property p_tmr_keep;
    take && src_q == 4'(FLG_TMR1) && flg_q[FLG_TMR1] && !wr_hit
      |=> flg_q[FLG_TMR1];
  endproperty
  a_tmr_keep: assert property (p_tmr_keep)
    else $error("timer flag lost at acceptance");

  property p_sources_set;
    (PERIPH_EVT_I.tmr_match[2] |=> flg_q[FLG_TMR2]) and
      (PERIPH_EVT_I.bit_ovf |=> flg_q[FLG_BIT]);
  endproperty
  a_sources_set: assert property (p_sources_set)
    else $error("peripheral event lost");

  property p_shared_vec;
    req_q && src_q == 4'(FLG_WT) |-> vec_q == VEC_WDT;
  endproperty
  a_shared_vec: assert property (p_shared_vec)
    else $error("watch timer not on watchdog vector");

  property p_brk_bypass;
    SOFTWARE_BREAK_I && !men && (st_q == ST_IDLE) && !req_q
      |=> ##1 req_q && vec_q == VEC_BRK;
  endproperty
  a_brk_bypass: assert property (p_brk_bypass)
    else $error("break not requested without master enable");

  c_accept: cover property (take ##8 acc_done);
  c_brk:    cover property (take_brk);
  c_ext:    cover property (take && src_q == 4'(FLG_EXT3));
  c_int:    cover property ($rose(int_q));

endmodule : pic_ctrl

//--- rtl/pic_edge_det.sv
`timescale 1ns/100ps
module pic_edge_det
  import pic_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      ce_i,
  input  wire logic      pin_i,
  input  wire pic_edge_t mode_i,
  output logic           edge_o
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;
  logic edge_q, edge_d;

  always_comb
  begin
    meta_d = pin_i;
    sync_d = meta_q;
    prev_d = sync_q;
    case (mode_i)
      EDGE_FALL: edge_d = prev_q & ~sync_q;
      EDGE_RISE: edge_d = ~prev_q & sync_q;
      EDGE_BOTH: edge_d = prev_q ^ sync_q;
      default:   edge_d = 1'b0;
    endcase
  end

  // Pin held high through reset reads as a rising edge once released
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      edge_q <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      edge_q <= edge_d;
    end
  end

  assign edge_o = edge_q;

endmodule : pic_edge_det

//--- rtl/pic_pkg.sv
package pic_pkg;

  localparam int unsigned PIC_NUM_EXT   = 4;
  localparam int unsigned PIC_NUM_FLAGS = 16;
  localparam int unsigned PIC_NUM_PRIO  = 11;

  // Byte offsets of the register words
  localparam logic [7:0] OFF_EN_HIGH   = 8'h00;
  localparam logic [7:0] OFF_EN_LOW    = 8'h04;
  localparam logic [7:0] OFF_FLG_HIGH  = 8'h08;
  localparam logic [7:0] OFF_FLG_LOW   = 8'h0c;
  localparam logic [7:0] OFF_EDGE_SEL  = 8'h10;
  localparam logic [7:0] OFF_INT_STAT  = 8'h14;
  localparam logic [7:0] OFF_INT_MASK  = 8'h18;
  localparam logic [7:0] OFF_CTRL_STAT = 8'h1c;

  // Flag positions; high byte is bits 15:8 of the flag vector
  localparam int unsigned FLG_EXT0  = 14;
  localparam int unsigned FLG_EXT3  = 11;
  localparam int unsigned FLG_TMR0  = 7;
  localparam int unsigned FLG_TMR1  = 6;
  localparam int unsigned FLG_TMR2  = 5;
  localparam int unsigned FLG_WT    = 3;
  localparam int unsigned FLG_ADC   = 2;
  localparam int unsigned FLG_WDT   = 1;
  localparam int unsigned FLG_BIT   = 0;
  localparam logic [15:0] FLG_USED_MASK = 16'h78ef;

  // Highest priority first; watch timer ranks just below the watchdog
  localparam logic [3:0] PRIO_ORDER [PIC_NUM_PRIO] = '{
    4'he, 4'hd, 4'hc, 4'hb, 4'h7, 4'h6, 4'h5, 4'h2, 4'h1, 4'h3, 4'h0};

  localparam logic [3:0] VEC_BRK = 4'hf;
  localparam logic [3:0] VEC_WDT = 4'h1;

  localparam int unsigned PSW_MEN_BIT = 2;

  localparam int unsigned STAT_ACCEPT = 0;
  localparam int unsigned STAT_EXT    = 1;
  localparam int unsigned STAT_BRK    = 2;
  localparam int unsigned STAT_W      = 3;

  localparam logic [15:0] RST_EN   = 16'h0000;
  localparam logic [15:0] RST_FLG  = 16'h0000;
  localparam logic [7:0]  RST_EDGE = 8'h00;
  localparam logic [2:0]  RST_STAT = 3'h0;
  localparam logic [2:0]  RST_MASK = 3'h0;

  localparam int unsigned ACCEPT_CYCLES = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } pic_edge_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCEPT = 2'b01
  } pic_state_t;

  typedef struct packed {
    logic [2:0] tmr_match;
    logic       adc_done;
    logic       wdt_match;
    logic       wt_match;
    logic       bit_ovf;
  } pic_evt_t;

endpackage : pic_pkg

//--- test/pic_core_model.sv
`timescale 1ns/100ps
module pic_core_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic       mclr_i,
  input  wire logic       ie_set_i,
  input  wire logic [3:0] dly_i,
  output logic            ack_o,
  output logic [7:0]      psw_o
);
  logic [3:0] cnt_q;

  // Waits dly_i cycles of request so both prompt and slow cores are seen
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 4'h0;
      ack_o <= 1'b0;
      psw_o <= 8'h00;
    end
    else
    begin
      ack_o <= req_i && !ack_o && (cnt_q >= dly_i);
      cnt_q <= req_i ? cnt_q + 4'h1 : 4'h0;
      if (mclr_i)
        psw_o[2] <= 1'b0;
      else if (ie_set_i)
        psw_o[2] <= 1'b1;
    end
  end
endmodule : pic_core_model

//--- test/prioritized_interrupt_controller_bench.sv
`timescale 1ns/100ps
module prioritized_interrupt_controller_bench
  import pic_pkg::*;
;
  logic        clk, rst_n, software_break, ack, ie_set, req, busy, mclr, int_o;
  logic        awv, awr, wv, wrd, bready, bv, arv, arr, rready, rv;
  logic [3:0]  pins, vec, dly;
  logic [7:0]  processor_status_word, aa, ra;
  logic [31:0] wd, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] fl;
  pic_evt_t    evt;
  int          err_count, tests_run, n;
  logic [3:0]  ord [9] = '{4'hd, 4'hc, 4'h7, 4'h6, 4'h5, 4'h2, 4'h1,
                           4'h3, 4'h0};

  pic_ctrl pic_ctrl_i (.MCLK_I(clk), .NRST_I(rst_n), .CE_I(1'b1),
    .EXT_IRQ_PIN_I(pins), .PERIPH_EVT_I(evt), .SOFTWARE_BREAK_I(software_break),
    .PROCESSOR_STATUS_WORD_I(processor_status_word), .IRQ_ACK_I(ack), .IRQ_REQ_O(req),
    .IRQ_VECTOR_O(vec), .ACCEPT_BUSY_O(busy), .MASTER_EN_CLEAR_O(mclr),
    .INT_O(int_o), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_AWADDR_I(aa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'h1), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ra),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp));

  pic_core_model pic_core_model_i (.clk_i(clk), .rst_n_i(rst_n),
    .req_i(req), .mclr_i(mclr), .ie_set_i(ie_set), .dly_i(dly),
    .ack_o(ack), .psw_o(processor_status_word));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task wrap_up;
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // Readies are registered, so the level at the falling edge is the one
  // sampled at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d,
          input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tb;
    ta = 0;
    tw = 0;
    tb = 0;
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    aa <= a;
    wd <= d;
    bready <= 1;
    while (!tb)
    begin
      @(negedge clk);
      ta = ta | awr;
      tw = tw | wrd;
      tb = bv;
      if (tb)
        chk("bresp", er, bresp);
      @(posedge clk);
      if (ta)
        awv <= 0;
      if (tw)
        wv <= 0;
      if (tb)
        bready <= 0;
    end
    @(negedge clk);
    chk("bvalid", 0, bv);
    @(posedge clk);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e,
          input logic [1:0] er = RESP_OKAY);
    logic ta, tb;
    ta = 0;
    tb = 0;
    @(posedge clk);
    arv <= 1;
    ra <= a;
    rready <= 1;
    while (!tb)
    begin
      @(negedge clk);
      ta = ta | arr;
      tb = rv;
      if (tb)
      begin
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
      end
      @(posedge clk);
      if (ta)
        arv <= 0;
      if (tb)
        rready <= 0;
    end
    @(negedge clk);
    chk("rvalid", 0, rv);
    @(posedge clk);
  endtask : rd

  task wait_req;
    for (n = 0; n < 100 && req !== 1'b1; n++)
      @(negedge clk);
    chk("req", 1, req);
  endtask : wait_req

  task pulse_ie;
    @(posedge clk);
    ie_set <= 1;
    @(posedge clk);
    ie_set <= 0;
  endtask : pulse_ie

  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    err_count++;
    wrap_up;
  end

  initial
  begin
    {rst_n, software_break, ie_set, awv, wv, bready, arv, rready} = '0;
    {pins, dly, aa, ra, wd} = '0;
    evt = '0;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 8; i++)
      // Idle source and vector fields show the break code
      rd(8'(i * 4), (i == 7) ? {VEC_BRK, VEC_BRK} : 0);
    rd(8'h20, 0, RESP_SLVERR);
    wr(8'h20, 1, RESP_SLVERR);
    wr(OFF_EN_HIGH, 32'hff);
    rd(OFF_EN_HIGH, 32'h78);
    wr(OFF_EN_LOW, 32'hff);
    rd(OFF_EN_LOW, 32'hef);
    wr(OFF_EDGE_SEL, 32'h36);
    pins <= 4'hf;
    repeat (8) @(posedge clk);
    rd(OFF_FLG_HIGH, 32'h50);
    wr(OFF_FLG_HIGH, 0);
    pins <= 4'h0;
    repeat (8) @(posedge clk);
    rd(OFF_FLG_HIGH, 32'h30);
    evt <= pic_evt_t'(7'h7f);
    @(posedge clk);
    evt <= '0;
    rd(OFF_FLG_LOW, 32'hef);
    fl = 16'h30ef;
    repeat (5) @(negedge clk);
    chk("req", 0, req);
    wr(OFF_EN_HIGH, 0);
    wr(OFF_EN_LOW, 0);
    pulse_ie;
    repeat (5) @(negedge clk);
    chk("req", 0, req);
    rd(OFF_FLG_LOW, 32'hef);
    for (int i = 0; i < 9; i++)
    begin
      dly <= 4'(i % 3 * 3);
      // Master enable is still set, so the first enable write starts
      // the first acceptance; low byte waits until enable is cleared
      if (i == 1)
        wr(OFF_EN_LOW, 32'hff);
      if (i == 0)
        wr(OFF_EN_HIGH, 32'hff);
      else
        pulse_ie;
      wait_req;
      chk("vector", (ord[i] == 4'(FLG_WT)) ? VEC_WDT : ord[i],
          vec);
      n = 0;
      repeat (40)
      begin
        @(negedge clk);
        if (busy === 1'b1)
          n++;
      end
      chk("busy", ACCEPT_CYCLES, n);
      chk("ie", 0, processor_status_word[2]);
      if (ord[i] > 4'h7)
        fl[ord[i]] = 0;
      rd(OFF_FLG_HIGH, 32'(fl[15:8]));
      rd(OFF_FLG_LOW, 32'(fl[7:0]));
      fl[ord[i]] = 0;
      wr(OFF_FLG_LOW, 32'(fl[7:0]));
    end
    software_break <= 1;
    @(posedge clk);
    software_break <= 0;
    wait_req;
    chk("vector", VEC_BRK, vec);
    repeat (40) @(posedge clk);
    pins <= 4'h1;
    repeat (8) @(posedge clk);
    pulse_ie;
    wait_req;
    chk("vector", 4'(FLG_EXT0), vec);
    repeat (20) @(posedge clk);
    rd(OFF_FLG_HIGH, 0);
    wr(OFF_INT_MASK, 1);
    repeat (3) @(negedge clk);
    chk("int", 1, int_o);
    wr(OFF_INT_STAT, 7);
    repeat (3) @(negedge clk);
    chk("int", 0, int_o);
    rd(OFF_INT_STAT, 0);
    wrap_up;
  end
endmodule : prioritized_interrupt_controller_bench
